// file: verilog/qpic_dev.sv
`timescale 1ns/1ps
`default_nettype none
module qpic_dev
  import qpic_pkg::*;
#(
  parameter logic [3:0] P_TYPE_CODE   = TYPE_CODE_DFLT,
  parameter int         P_PROG_CYCLES = NV_PROG_CYCLES
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  // link
  qpic_link_if.dev                           link,
  // strap pins
  input  wire logic [3:0]                    i_strap_addr,
  // pot state
  output logic      [N_POT-1:0][WIPER_W-1:0] o_wiper,
  output logic                               o_prog_busy
);
  localparam int PW = $clog2(P_PROG_CYCLES + 1);

  // link clock side: gray count of rising edges and the sampled bit
  typedef struct packed {
    logic [1:0] gray;
    logic       bit_v;
  } qpic_lk_st_t;

  typedef struct packed {
    qpic_phase_t                    ph;
    qpic_phase_t                    nxt;
    logic [3:0]                     bitn;
    logic [7:0]                     sh;
    logic [3:0]                     op;
    logic [1:0]                     slot;
    logic [1:0]                     pot;
    logic [8:0]                     tx;
    logic [3:0]                     txn;
    logic                           sda_oe_n;
    logic [1:0]                     seen;
    logic                           scl_d;
    logic                           sda_d;
    logic                           step_pend;
    logic                           step_up;
    logic [PW-1:0]                  prog;
    logic                           busy;
    logic [N_POT-1:0][WIPER_W-1:0]  wiper;
    logic [15:0][WIPER_W-1:0]       nv;
  } qpic_dev_st_t;

  qpic_lk_st_t   lk_q;
  qpic_dev_st_t  q;
  qpic_dev_st_t  d;
  logic          scl_s;
  logic          sda_s;
  logic [1:0]    gray_s;
  logic [3:0]    strap_s;
  logic          bit_ev;
  logic          scl_fall;
  logic          start_ev;
  logic          stop_ev;
  logic [7:0]    byte_v;
  logic [5:0]    wsel;

  // clock stops outside frames, so reset acts without it
  always_ff @(posedge link.scl or posedge i_srst) begin
    if (i_srst) begin
      lk_q <= '0;
    end else begin
      lk_q.gray  <= {lk_q.gray[0], ~lk_q.gray[1]};
      lk_q.bit_v <= link.sda;
    end
  end

  qpic_sync #(.W(8)) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({link.scl, link.sda, lk_q.gray, i_strap_addr}),
    .o_q    ({scl_s, sda_s, gray_s, strap_s})
  );

  // bit value is stable for a whole clock period after the count moves
  assign bit_ev   = (gray_s != q.seen);
  assign scl_fall = q.scl_d & ~scl_s;
  assign start_ev = scl_s & q.scl_d & q.sda_d & ~sda_s;
  assign stop_ev  = scl_s & q.scl_d & ~q.sda_d & sda_s;
  assign byte_v   = {q.sh[6:0], lk_q.bit_v};
  assign wsel     = q.wiper[q.pot];

  always_comb begin
    d       = q;
    d.scl_d = scl_s;
    d.sda_d = sda_s;
    d.seen  = gray_s;
    if (q.prog != '0) begin
      d.prog = q.prog - 1'b1;
    end
    if (scl_fall) begin
      if (q.txn != '0) begin
        d.sda_oe_n = q.tx[8];
        d.tx       = {q.tx[7:0], 1'b1};
        d.txn      = q.txn - 1'b1;
      end else begin
        d.sda_oe_n = 1'b1;
      end
      // step lands at end of pulse
      if (q.step_pend) begin
        d.step_pend = 1'b0;
        if (q.step_up) begin
          if (wsel != WIPER_MAX) begin
            d.wiper[q.pot] = wsel + 6'h01;
          end
        end else if (wsel != WIPER_MIN) begin
          d.wiper[q.pot] = wsel - 6'h01;
        end
      end
    end
    if (bit_ev && q.ph != PH_IDLE && q.ph != PH_SKIP) begin
      d.sh   = byte_v;
      d.bitn = q.bitn + 4'h1;
      if (q.ph == PH_STEP) begin
        d.step_pend = 1'b1;
        d.step_up   = lk_q.bit_v;
      end else if (q.bitn == ACK_SLOT) begin
        d.bitn = '0;
        d.ph   = q.nxt;
      end else if (q.bitn == BYTE_LAST_BIT) begin
        unique case (q.ph)
          PH_ADDR: begin
            if (byte_v[OP_HI:OP_LO] == P_TYPE_CODE &&
                byte_v[SLOT_HI:POT_LO] == strap_s && !q.busy) begin
              d.tx  = TX_ACK;
              d.txn = TX_LEN_ACK;
              d.nxt = PH_INSTR;
            end else begin
              d.ph = PH_SKIP;
            end
          end
          PH_INSTR: begin
            d.op   = byte_v[OP_HI:OP_LO];
            d.slot = byte_v[SLOT_HI:SLOT_LO];
            d.pot  = byte_v[POT_HI:POT_LO];
            d.tx   = TX_ACK;
            d.txn  = TX_LEN_ACK;
            d.nxt  = PH_SKIP;
            unique case (byte_v[OP_HI:OP_LO])
              OP_RD_WIPER: begin
                d.tx  = {1'b0, 2'b00, q.wiper[byte_v[POT_HI:POT_LO]]};
                d.txn = TX_LEN_READ;
                d.nxt = PH_RDATA;
              end
              OP_RD_NV: begin
                d.tx  = {1'b0, 2'b00, q.nv[byte_v[SLOT_HI:POT_LO]]};
                d.txn = TX_LEN_READ;
                d.nxt = PH_RDATA;
              end
              OP_WR_WIPER, OP_WR_NV: begin
                d.nxt = PH_WDATA;
              end
              OP_RESTORE: begin
                d.wiper[byte_v[POT_HI:POT_LO]] = q.nv[byte_v[SLOT_HI:POT_LO]];
              end
              OP_SAVE: begin
                d.nv[byte_v[SLOT_HI:POT_LO]] = q.wiper[byte_v[POT_HI:POT_LO]];
                d.prog = PW'(P_PROG_CYCLES);
              end
              OP_G_RESTORE: begin
                for (int i = 0; i < N_POT; i++) begin
                  d.wiper[i] = q.nv[{byte_v[SLOT_HI:SLOT_LO], 2'(i)}];
                end
              end
              OP_G_SAVE: begin
                for (int i = 0; i < N_POT; i++) begin
                  d.nv[{byte_v[SLOT_HI:SLOT_LO], 2'(i)}] = q.wiper[i];
                end
                d.prog = PW'(P_PROG_CYCLES);
              end
              OP_STEP: begin
                d.nxt = PH_STEP;
              end
              default: begin
                d.txn = '0;
                d.ph  = PH_SKIP;
              end
            endcase
          end
          PH_WDATA: begin
            if (q.op == OP_WR_WIPER) begin
              d.wiper[q.pot] = byte_v[WIPER_W-1:0];
            end else begin
              d.nv[{q.slot, q.pot}] = byte_v[WIPER_W-1:0];
              d.prog = PW'(P_PROG_CYCLES);
            end
            d.tx  = TX_ACK;
            d.txn = TX_LEN_ACK;
            d.nxt = PH_SKIP;
          end
          PH_RDATA: begin
            d.nxt = PH_SKIP;
          end
          default: begin
            d.nxt = PH_SKIP;
          end
        endcase
      end
    end
    // start or stop ends whatever the frame was doing
    if (start_ev || stop_ev) begin
      d.ph        = start_ev ? PH_ADDR : PH_IDLE;
      d.bitn      = '0;
      d.txn       = '0;
      d.sda_oe_n  = 1'b1;
      d.step_pend = 1'b0;
    end
    d.busy = (d.prog != '0);
    if (i_srst) begin
      d          = '0;
      d.sda_oe_n = 1'b1;
      d.seen     = gray_s;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = q.sda_oe_n;
  assign o_wiper           = q.wiper;
  assign o_prog_busy       = q.busy;
endmodule // qpic_dev
`default_nettype wire

// file: verilog/qpic_pkg.sv
// Functional notes
// - after acked step command, every clock steps wiper
// - pulse sampled with data high steps up
// - pulse sampled with data low steps down
// - global restore loads all wipers from slot
// - global save stores all wipers into slot
// - wiper read: addr, instr, one data byte
// - wiper write: addr, instr, one data byte
// - stored read returns byte, two msbs zero
// - stored write data sent with msbs zero
// - global restore two bytes, pot bits zero
// - global save two bytes, low bits zero
// - single save copies wiper into slot
// - single restore loads wiper from slot
// - step frame: instr, then any direction bits
// - stored change starts nonvolatile programming cycle
// - act only on matching type and strap
// - slot bits pick slots zero to three
// - two low instr bits pick pot
// - programming completes within five milliseconds
`default_nettype none
package qpic_pkg;
  // device type code; value is arbitrary
  localparam logic [3:0] TYPE_CODE_DFLT  = 4'ha;
  // instruction opcodes, upper nibble of instruction byte
  localparam logic [3:0] OP_RD_WIPER     = 4'h9;
  localparam logic [3:0] OP_WR_WIPER     = 4'ha;
  localparam logic [3:0] OP_RD_NV        = 4'hb;
  localparam logic [3:0] OP_WR_NV        = 4'hc;
  localparam logic [3:0] OP_RESTORE      = 4'hd;
  localparam logic [3:0] OP_SAVE         = 4'he;
  localparam logic [3:0] OP_G_RESTORE    = 4'h1;
  localparam logic [3:0] OP_G_SAVE       = 4'h8;
  localparam logic [3:0] OP_STEP         = 4'h2;
  // field layout of address and instruction bytes
  localparam int         OP_HI           = 7;
  localparam int         OP_LO           = 4;
  localparam int         SLOT_HI         = 3;
  localparam int         SLOT_LO         = 2;
  localparam int         POT_HI          = 1;
  localparam int         POT_LO          = 0;
  localparam int         N_POT           = 4;
  localparam int         WIPER_W         = 6;
  localparam logic [5:0] WIPER_MAX       = 6'h3f;
  localparam logic [5:0] WIPER_MIN       = 6'h00;
  // byte slot counting on the device
  localparam logic [3:0] BYTE_LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT        = 4'h8;
  localparam logic [8:0] TX_ACK          = 9'h0ff;
  localparam logic [3:0] TX_LEN_ACK      = 4'h1;
  localparam logic [3:0] TX_LEN_READ     = 4'h9;
  // timing
  localparam int         CLK_MHZ         = 200;
  localparam int         NV_PROG_TIME_MS = 5;
  localparam int         NV_PROG_CYCLES  = NV_PROG_TIME_MS * CLK_MHZ * 1000;
  localparam int         SCL_KHZ         = 400;
  localparam int         SCL_QTR_CYCLES  = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  // host frame layout, bit indices from the first address bit
  localparam int         FRAME_W         = 27;
  localparam logic [8:0] FRAME2_BITS     = 9'h012;
  localparam logic [8:0] FRAME3_BITS     = 9'h01b;
  localparam logic [8:0] HOST_ACK_ADDR   = 9'h008;
  localparam logic [8:0] HOST_ACK_INSTR  = 9'h011;
  localparam logic [8:0] HOST_ACK_DATA   = 9'h01a;
  localparam logic [8:0] HOST_RD_LAST    = 9'h019;
  localparam logic [8:0] TAIL_READ       = 9'h1fe;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_ADDR  = 3'b001,
    PH_INSTR = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100,
    PH_STEP  = 3'b101,
    PH_SKIP  = 3'b110
  } qpic_phase_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_START = 2'b01,
    HS_BITS  = 2'b10,
    HS_STOP  = 2'b11
  } qpic_hstate_t;
endpackage
`default_nettype wire

// file: verilog/qpic_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qpic_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // open-drain wires with pull-up: low wins where any end drives
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
    input  scl, sda
  );
  modport dev (
    output dev_sda_o, dev_sda_oe_n,
    input  scl, sda
  );
endinterface
`default_nettype wire

// file: verilog/qpic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qpic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // levels in and out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } qpic_sync_st_t;

  qpic_sync_st_t s_q;
  qpic_sync_st_t s_d;

  always_comb begin
    s_d.meta = i_d;
    s_d.q    = s_q.meta;
    if (i_srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  assign o_q = s_q.q;
endmodule // qpic_sync
`default_nettype wire

// file: verilog/qpic_host.sv
`timescale 1ns/1ps
`default_nettype none
module qpic_host
  import qpic_pkg::*;
#(
  parameter logic [3:0] P_TYPE_CODE = TYPE_CODE_DFLT,
  parameter int         P_QTR       = SCL_QTR_CYCLES
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // link
  qpic_link_if.host       link,
  // command
  input  wire logic       i_req,
  input  wire logic [3:0] i_target,
  input  wire logic [3:0] i_op,
  input  wire logic [1:0] i_slot,
  input  wire logic [1:0] i_pot,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_steps,
  input  wire logic       i_step_up,
  // answer
  output logic            o_ready,
  output logic            o_done,
  output logic            o_nack,
  output logic [7:0]      o_rdata
);
  localparam int QW = $clog2(P_QTR + 1);

  typedef struct packed {
    qpic_hstate_t       st;
    logic [1:0]         qph;
    logic [QW-1:0]      cnt;
    logic [8:0]         idx;
    logic [8:0]         nbits;
    logic [FRAME_W-1:0] tx;
    logic [7:0]         rx;
    logic               dir;
    logic               wr;
    logic               abort;
    logic               scl_oe_n;
    logic               sda_oe_n;
    logic               ready;
    logic               done;
    logic               nack;
    logic [7:0]         rdata;
  } qpic_host_st_t;

  qpic_host_st_t q;
  qpic_host_st_t d;
  logic          sda_s;
  logic          tick;
  logic          is_rd;
  logic          is_wr;
  logic          is_step;
  logic          is_glob;
  logic          is_wip;
  logic [7:0]    instr;
  logic [7:0]    dbyte;
  logic [8:0]    tail;

  qpic_sync #(.W(1)) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    (link.sda),
    .o_q    (sda_s)
  );

  assign tick    = (q.cnt == '0);
  assign is_rd   = (i_op == OP_RD_WIPER) || (i_op == OP_RD_NV);
  assign is_wr   = (i_op == OP_WR_WIPER) || (i_op == OP_WR_NV);
  assign is_step = (i_op == OP_STEP);
  assign is_glob = (i_op == OP_G_RESTORE) || (i_op == OP_G_SAVE);
  assign is_wip  = (i_op == OP_RD_WIPER) || (i_op == OP_WR_WIPER) || is_step;
  assign instr   = {i_op, is_wip ? 2'b00 : i_slot, is_glob ? 2'b00 : i_pot};
  assign dbyte   = (i_op == OP_WR_NV) ? {2'b00, i_wdata[5:0]} : i_wdata;
  assign tail    = is_wr ? {dbyte, 1'b1} : is_rd ? TAIL_READ : {9{i_step_up}};

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (q.st != HS_IDLE) begin
      d.cnt = tick ? QW'(P_QTR - 1) : q.cnt - 1'b1;
      if (tick) begin
        d.qph = q.qph + 2'b01;
      end
    end
    unique case (q.st)
      HS_IDLE: begin
        if (i_req) begin
          d.st    = HS_START;
          d.qph   = 2'b00;
          d.cnt   = QW'(P_QTR - 1);
          d.ready = 1'b0;
          d.nack  = 1'b0;
          d.abort = 1'b0;
          d.wr    = is_wr;
          d.dir   = i_step_up;
          d.tx    = {P_TYPE_CODE, i_target, 1'b1, instr, 1'b1, tail};
          d.nbits = (is_rd || is_wr) ? FRAME3_BITS :
                    is_step ? FRAME2_BITS + {1'b0, i_steps} : FRAME2_BITS;
        end
      end
      HS_START: begin
        if (tick && q.qph == 2'b01) begin
          d.sda_oe_n = 1'b0;
        end
        if (tick && q.qph == 2'b11) begin
          d.scl_oe_n = 1'b0;
          d.st       = HS_BITS;
          d.idx      = '0;
        end
      end
      HS_BITS: begin
        if (tick) begin
          unique case (q.qph)
            2'b00: d.sda_oe_n = q.tx[FRAME_W-1];
            2'b01: d.scl_oe_n = 1'b1;
            2'b10: begin
              d.rx = {q.rx[6:0], sda_s};
              if (q.idx == HOST_RD_LAST) begin
                d.rdata = {q.rx[6:0], sda_s};
              end
              if (sda_s && (q.idx == HOST_ACK_ADDR || q.idx == HOST_ACK_INSTR ||
                            (q.wr && q.idx == HOST_ACK_DATA))) begin
                d.abort = 1'b1;
                d.nack  = 1'b1;
              end
            end
            2'b11: begin
              d.scl_oe_n = 1'b0;
              d.tx       = {q.tx[FRAME_W-2:0], q.dir};
              d.idx      = q.idx + 9'h001;
              if (q.abort || q.idx == q.nbits - 9'h001) begin
                d.st = HS_STOP;
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          unique case (q.qph)
            2'b00: d.sda_oe_n = 1'b0;
            2'b01: d.scl_oe_n = 1'b1;
            2'b10: d.sda_oe_n = 1'b1;
            2'b11: begin
              d.st    = HS_IDLE;
              d.ready = 1'b1;
              d.done  = 1'b1;
            end
          endcase
        end
      end
    endcase
    if (i_srst) begin
      d          = '0;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
      d.ready    = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign link.host_scl_o    = 1'b0;
  assign link.host_sda_o    = 1'b0;
  assign link.host_scl_oe_n = q.scl_oe_n;
  assign link.host_sda_oe_n = q.sda_oe_n;
  assign o_ready            = q.ready;
  assign o_done             = q.done;
  assign o_nack             = q.nack;
  assign o_rdata            = q.rdata;
endmodule // qpic_host
`default_nettype wire

// file: sim/qpic_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module qpic_link_monitor
  import qpic_pkg::*;
#(
  parameter logic [3:0] P_TYPE_CODE   = TYPE_CODE_DFLT,
  parameter logic [3:0] P_STRAP       = 4'h0,
  parameter int         P_PROG_CYCLES = NV_PROG_CYCLES
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  // wired link
  input  wire logic                          scl,
  input  wire logic                          sda,
  // device state
  input  wire logic [N_POT-1:0][WIPER_W-1:0] o_wiper,
  input  wire logic                          o_prog_busy
);
  typedef struct packed {
    logic        scl;
    logic        sda;
    logic        busy_seen;
    logic [7:0]  cnt;
    logic [15:0] sh;
    logic [7:0]  ins;
    logic [5:0]  step_exp;
    logic [31:0] busy_cnt;
  } qpic_mon_t;
  qpic_mon_t  s_q;
  qpic_mon_t  s_d;
  logic       rise;
  logic       fall;
  logic       start;
  logic       known;
  logic [5:0] w_sel;
  logic [2:0] rd_idx;

  // frame tracker: rises counted from the start condition
  always_comb begin
    rise   = scl && !s_q.scl;
    fall   = !scl && s_q.scl;
    start  = scl && s_q.scl && s_q.sda && !sda;
    w_sel  = o_wiper[s_q.ins[POT_HI:POT_LO]];
    rd_idx = 3'(8'h19 - s_q.cnt);
    known  = s_q.sh[7:4] inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_NV, OP_WR_NV, OP_RESTORE,
                                 OP_SAVE, OP_G_RESTORE, OP_G_SAVE, OP_STEP};
    s_d          = s_q;
    s_d.scl      = scl;
    s_d.sda      = sda;
    s_d.busy_cnt = o_prog_busy ? s_q.busy_cnt + 32'h1 : 32'h0;
    s_d.busy_seen = s_q.busy_seen | o_prog_busy;
    if (start) begin
      s_d.cnt       = 8'h00;
      s_d.ins       = 8'h00;
      s_d.busy_seen = o_prog_busy;
    end
    if (rise) begin
      s_d.sh = {s_q.sh[14:0], sda};
      if (s_q.cnt != 8'hff) s_d.cnt = s_q.cnt + 8'h01;
      if (s_q.cnt == 8'h11) s_d.ins = s_q.sh[7:0];
    end
    if (fall) begin
      if (s_q.sh[0]) s_d.step_exp = (w_sel == WIPER_MAX) ? w_sel : w_sel + 6'h01;
      else s_d.step_exp = (w_sel == WIPER_MIN) ? w_sel : w_sel - 6'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) s_q <= qpic_mon_t'{scl: 1'b1, sda: 1'b1, default: '0};
    else s_q <= s_d;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_addr_slot;
    rise && s_q.cnt == 8'h08;
  endsequence
  sequence s_step_fall;
    fall && s_q.ins[7:4] == OP_STEP && s_q.cnt >= 8'h13;
  endsequence

  property p_addr_ack;
    s_addr_slot ##0 (s_q.sh[7:0] == {P_TYPE_CODE, P_STRAP} && !o_prog_busy && !s_q.busy_seen)
      |-> !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");
  property p_addr_refuse;
    s_addr_slot ##0 (s_q.sh[7:0] != {P_TYPE_CODE, P_STRAP} || o_prog_busy) |-> sda;
  endproperty
  a_addr_refuse: assert property (p_addr_refuse) else $error("address wrongly acked");
  property p_instr_ack;
    rise && s_q.cnt == 8'h11 |-> sda == !known;
  endproperty
  a_instr_ack: assert property (p_instr_ack) else $error("instruction ack wrong");
  property p_rd_wiper;
    rise && s_q.cnt inside {[8'h12:8'h19]} && s_q.ins[7:4] == OP_RD_WIPER
      |-> sda == ({2'b00, w_sel} >> rd_idx) % 2;
  endproperty
  a_rd_wiper: assert property (p_rd_wiper) else $error("wiper read bit wrong");
  property p_rd_nv_top;
    rise && s_q.cnt inside {8'h12, 8'h13} && s_q.ins[7:4] == OP_RD_NV |-> !sda;
  endproperty
  a_rd_nv_top: assert property (p_rd_nv_top) else $error("stored read msb not zero");
  property p_nv_prog;
    rise && s_q.cnt == 8'h1a && s_q.ins[7:4] == OP_WR_NV |-> o_prog_busy;
  endproperty
  a_nv_prog: assert property (p_nv_prog) else $error("no programming after write");
  property p_prog_len;
    $fell(o_prog_busy) |-> s_q.busy_cnt >= P_PROG_CYCLES - 1 && s_q.busy_cnt <= P_PROG_CYCLES + 1;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming time wrong");
  property p_step_up;
    s_step_fall ##0 s_q.sh[0] |=> ##[0:11] o_wiper[s_q.ins[1:0]] == s_q.step_exp;
  endproperty
  a_step_up: assert property (p_step_up) else $error("wiper did not step up");
  property p_step_down;
    s_step_fall ##0 !s_q.sh[0] |=> ##[0:11] o_wiper[s_q.ins[1:0]] == s_q.step_exp;
  endproperty
  a_step_down: assert property (p_step_down) else $error("wiper did not step down");
endmodule // qpic_link_monitor
`default_nettype wire

// file: sim/quad_pot_i2c_command_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_pot_i2c_command_engine_tb import qpic_pkg::*;;
  localparam logic [3:0] STRAP = 4'h5;
  localparam int         PROG  = 3000;
  typedef struct packed {
    logic [3:0]  op;
    logic [1:0]  slot;
    logic [1:0]  pot;
    logic [7:0]  arg;
    logic        up;
    logic [23:0] exp_w;
  } qpic_row_t;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       req = 1'b0;
  logic [3:0] target = STRAP;
  qpic_row_t  cmd = '0;
  logic       ready;
  logic       done;
  logic       nack;
  logic [7:0] rdata;
  logic [N_POT-1:0][WIPER_W-1:0] wiper;
  logic       prog_busy;
  int         failures = 0;
  int         cmp_count = 0;
  // arg is write data, step count, or expected read byte
  qpic_row_t  rows [20] = '{
    '{OP_WR_WIPER, 2'h0, 2'h0, 8'h2a, 1'b0, 24'h00_002a},
    '{OP_WR_WIPER, 2'h0, 2'h3, 8'h3f, 1'b0, 24'hfc_002a},
    '{OP_RD_WIPER, 2'h0, 2'h0, 8'h2a, 1'b0, 24'hfc_002a},
    '{OP_SAVE, 2'h2, 2'h0, 8'h00, 1'b0, 24'hfc_002a},
    '{OP_WR_WIPER, 2'h0, 2'h0, 8'h05, 1'b0, 24'hfc_0005},
    '{OP_RESTORE, 2'h2, 2'h0, 8'h00, 1'b0, 24'hfc_002a},
    '{OP_WR_NV, 2'h1, 2'h1, 8'hff, 1'b0, 24'hfc_002a},
    '{OP_RD_NV, 2'h1, 2'h1, 8'h3f, 1'b0, 24'hfc_002a},
    '{OP_RD_NV, 2'h0, 2'h0, 8'h00, 1'b0, 24'hfc_002a},
    '{OP_RD_NV, 2'h2, 2'h0, 8'h2a, 1'b0, 24'hfc_002a},
    '{OP_G_SAVE, 2'h3, 2'h0, 8'h00, 1'b0, 24'hfc_002a},
    '{OP_WR_WIPER, 2'h0, 2'h1, 8'h11, 1'b0, 24'hfc_046a},
    '{OP_WR_WIPER, 2'h0, 2'h3, 8'h00, 1'b0, 24'h00_046a},
    '{OP_G_RESTORE, 2'h3, 2'h0, 8'h00, 1'b0, 24'hfc_002a},
    '{OP_STEP, 2'h0, 2'h3, 8'h03, 1'b1, 24'hfc_002a},
    '{OP_STEP, 2'h0, 2'h0, 8'h05, 1'b0, 24'hfc_0025},
    '{OP_STEP, 2'h0, 2'h2, 8'h02, 1'b0, 24'hfc_0025},
    '{OP_STEP, 2'h0, 2'h1, 8'h04, 1'b1, 24'hfc_0125},
    '{OP_RD_NV, 2'h3, 2'h3, 8'h3f, 1'b0, 24'hfc_0125},
    '{OP_RD_WIPER, 2'h0, 2'h0, 8'h25, 1'b0, 24'hfc_0125}};

  qpic_link_if i_qpic_link_if ();
  qpic_host #(.P_QTR(8)) i_qpic_host (.i_clk(clk), .i_srst(srst), .link(i_qpic_link_if),
    .i_req(req), .i_target(target), .i_op(cmd.op), .i_slot(cmd.slot), .i_pot(cmd.pot),
    .i_wdata(cmd.arg), .i_steps(cmd.arg), .i_step_up(cmd.up), .o_ready(ready),
    .o_done(done), .o_nack(nack), .o_rdata(rdata));
  qpic_dev #(.P_PROG_CYCLES(PROG)) i_qpic_dev (.i_clk(clk), .i_srst(srst),
    .link(i_qpic_link_if), .i_strap_addr(STRAP), .o_wiper(wiper), .o_prog_busy(prog_busy));
  qpic_link_monitor #(.P_STRAP(STRAP), .P_PROG_CYCLES(PROG)) i_qpic_link_monitor (
    .i_clk(clk), .i_srst(srst), .scl(i_qpic_link_if.scl), .sda(i_qpic_link_if.sda),
    .o_wiper(wiper), .o_prog_busy(prog_busy));

  always #2.5 clk = ~clk;

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reset_dut();
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic do_cmd(input logic [3:0] t, input qpic_row_t r, input logic wait_busy);
    int n;
    @(posedge clk);
    req <= 1'b1;
    target <= t;
    cmd <= r;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 4000);
    check("done", 24'(done), 24'h00_0001);
    n = 0;
    while (wait_busy && prog_busy !== 1'b0 && n < PROG + 100) begin
      @(negedge clk);
      n++;
    end
    if (wait_busy) check("busy", 24'(prog_busy), 24'h00_0000);
  endtask

  task automatic final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    final_report();
  end

  initial begin
    reset_dut();
    @(negedge clk);
    check("wiper", wiper, 24'h00_0000);
    check("ready", 24'(ready), 24'h00_0001);
    foreach (rows[i]) begin
      do_cmd(STRAP, rows[i], 1'b1);
      check("nack", 24'(nack), 24'h00_0000);
      if (rows[i].op inside {OP_RD_WIPER, OP_RD_NV})
        check("rdata", 24'(rdata), 24'(rows[i].arg));
      check("wiper", wiper, rows[i].exp_w);
    end
    do_cmd(4'h6, '{OP_WR_WIPER, 2'h0, 2'h0, 8'h10, 1'b0, 24'h00_0000}, 1'b1);
    check("nack", 24'(nack), 24'h00_0001);
    check("wiper", wiper, 24'hfc_0125);
    do_cmd(STRAP, '{4'hf, 2'h0, 2'h0, 8'h00, 1'b0, 24'h00_0000}, 1'b1);
    check("nack", 24'(nack), 24'h00_0001);
    do_cmd(STRAP, '{OP_SAVE, 2'h0, 2'h1, 8'h00, 1'b0, 24'h00_0000}, 1'b0);
    check("busy", 24'(prog_busy), 24'h00_0001);
    do_cmd(STRAP, '{OP_RD_WIPER, 2'h0, 2'h0, 8'h00, 1'b0, 24'h00_0000}, 1'b1);
    check("nack", 24'(nack), 24'h00_0001);
    do_cmd(STRAP, '{OP_RD_NV, 2'h0, 2'h1, 8'h00, 1'b0, 24'h00_0000}, 1'b1);
    check("rdata", 24'(rdata), 24'h00_0004);
    // reset in mid-frame
    @(posedge clk);
    req <= 1'b1;
    cmd <= rows[0];
    @(posedge clk);
    req <= 1'b0;
    repeat (200) @(posedge clk);
    reset_dut();
    @(negedge clk);
    check("wiper", wiper, 24'h00_0000);
    check("ready", 24'(ready), 24'h00_0001);
    final_report();
  end
endmodule // quad_pot_i2c_command_engine_tb
`default_nettype wire
